// ==== rtl/dbr_cfg.svh ====
// Purpose: constants for the drop bus receiver
// Assumes: drop bus clock 19.44 MHz, system clock 10 MHz
// Notes: definitions only
`ifndef DBR_CFG_SVH
`define DBR_CFG_SVH
`define DBR_DATA_W 8
`define DBR_MSB 7
`define DBR_PTR_ZERO 2'h0
`define DBR_PTR_ONE 2'h1
`define DBR_PTR_TWO 2'h2
`define DBR_PTR_FULL 2'h3
`define DBR_BUF_DEPTH 2
`define DBR_SLOT_ZERO 1'h0
`define DBR_SLOT_ONE 1'h1
`endif

// ==== rtl/dbr_pkg.sv ====
// Purpose: types for the drop bus receiver
// Assumes: nothing beyond the cfg header
// Notes: word carried from link domain to system domain
package dbr_pkg;
    typedef struct packed {
        logic [7:0] data;
        logic frame_mark;
        logic path_mark;
        logic parity_err;
    } dbr_word_type;

    typedef struct packed {
        logic payload_window;
        logic marker;
        logic frame_pulse;
    } dbr_timing_type;
endpackage

// ==== rtl/dbr_receiver.sv ====
// Purpose: receive side of a byte-wide SDH/SONET drop bus
// Assumes: drop bus clock is its own domain, system clock 10 MHz
// Notes: payload bytes cross via a gray-pointer two-entry buffer
`timescale 1ns/1ps
`default_nettype none
`include "dbr_cfg.svh"

// How it works
// - one byte per drop clock at 19.44 Mbyte/s, bit 7 the most significant.
// - only payload-window bytes are kept; overhead bytes are dropped.
// - data, parity, window and both markers are sampled on the drop clock falling edge.
// - with add timing select low, add timing is the sampled window and markers, resynchronised to the system clock.
// - the composite marker is the OR of the frame pulse and the frame/path marker.
module dbr_receiver (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_drop_bus_clock,
    input wire logic [7:0] i_drop_data_byte,
    input wire logic i_drop_parity_bit,
    input wire logic i_drop_payload_window,
    input wire logic i_drop_frame_path_marker,
    input wire logic i_drop_frame_pulse,
    input wire logic i_add_timing_select,
    input wire logic i_out_ready,
    output logic o_out_valid,
    output var dbr_pkg::dbr_word_type o_out_word,
    output var dbr_pkg::dbr_timing_type o_add_timing,
    output logic o_add_timing_en,
    output logic o_parity_err,
    output logic o_overflow
);
    // ---------------- link domain (falling edge of drop clock) ----------------
    logic [7:0] smp_data_reg, smp_data_next;
    logic smp_par_reg, smp_par_next;
    logic smp_win_reg, smp_win_next;
    logic smp_mark_reg, smp_mark_next;
    logic smp_c1_reg, smp_c1_next;
    logic smp_vld_reg, smp_vld_next;
    logic perr_seen_reg, perr_seen_next;
    logic [1:0] wptr_reg, wptr_next;
    logic ovf_seen_reg, ovf_seen_next;
    logic [1:0] rg_s1_reg, rg_s2_reg;
    logic [1:0] rptr_reg;
    dbr_pkg::dbr_word_type mem_reg [0:`DBR_BUF_DEPTH-1];
    dbr_pkg::dbr_word_type mem_next [0:`DBR_BUF_DEPTH-1];
    logic parity_ok;
    logic full_link;
    logic [1:0] wptr_step;
    logic wr_slot;

    // odd parity over data, window, composite marker and parity bit
    assign parity_ok = ^{smp_data_reg, smp_win_reg, smp_mark_reg, smp_par_reg};
    // full when the write pointer is two entries ahead: both gray bits inverted
    assign full_link = (wptr_reg == (rg_s2_reg ^ `DBR_PTR_FULL));
    // gray step flips bit 0 on even parity and bit 1 on odd
    assign wptr_step = wptr_reg ^ (^wptr_reg ? `DBR_PTR_TWO : `DBR_PTR_ONE);
    // gray to binary low bit selects the buffer entry
    assign wr_slot = wptr_reg[1] ^ wptr_reg[0];

    // next-state for sampled inputs, parity check and buffer write side
    always_comb begin
        smp_data_next = i_drop_data_byte;
        smp_par_next = i_drop_parity_bit;
        smp_win_next = i_drop_payload_window;
        smp_mark_next = i_drop_frame_path_marker | i_drop_frame_pulse;
        smp_c1_next = i_drop_frame_pulse;
        smp_vld_next = 1'b1;
        perr_seen_next = perr_seen_reg;
        ovf_seen_next = ovf_seen_reg;
        wptr_next = wptr_reg;
        for (int k = 0; k < `DBR_BUF_DEPTH; k++) begin
            mem_next[k] = mem_reg[k];
        end
        // both flags are sticky levels so no event is lost crossing to the slower clock
        if (smp_vld_reg && !parity_ok) begin
            perr_seen_next = 1'b1;
        end
        if (smp_vld_reg && smp_win_reg) begin
            if (full_link) begin
                ovf_seen_next = 1'b1;
            end else begin
                mem_next[wr_slot].data = smp_data_reg;
                mem_next[wr_slot].path_mark = smp_mark_reg;
                mem_next[wr_slot].frame_mark = smp_c1_reg;
                mem_next[wr_slot].parity_err = !parity_ok;
                wptr_next = wptr_step;
            end
        end
    end

    // link-domain registers on falling edge
    always_ff @(negedge i_drop_bus_clock or posedge i_reset) begin
        if (i_reset) begin
            smp_data_reg <= 8'h00;
            smp_par_reg <= 1'b0;
            smp_win_reg <= 1'b0;
            smp_mark_reg <= 1'b0;
            smp_c1_reg <= 1'b0;
            smp_vld_reg <= 1'b0;
            perr_seen_reg <= 1'b0;
            ovf_seen_reg <= 1'b0;
            wptr_reg <= `DBR_PTR_ZERO;
            rg_s1_reg <= `DBR_PTR_ZERO;
            rg_s2_reg <= `DBR_PTR_ZERO;
            for (int k = 0; k < `DBR_BUF_DEPTH; k++) begin
                mem_reg[k] <= '0;
            end
        end else begin
            smp_data_reg <= smp_data_next;
            smp_par_reg <= smp_par_next;
            smp_win_reg <= smp_win_next;
            smp_mark_reg <= smp_mark_next;
            smp_c1_reg <= smp_c1_next;
            smp_vld_reg <= smp_vld_next;
            perr_seen_reg <= perr_seen_next;
            ovf_seen_reg <= ovf_seen_next;
            wptr_reg <= wptr_next;
            rg_s1_reg <= rptr_reg; // read pointer into link domain
            rg_s2_reg <= rg_s1_reg;
            for (int k = 0; k < `DBR_BUF_DEPTH; k++) begin
                mem_reg[k] <= mem_next[k];
            end
        end
    end

    // ---------------- system domain ----------------
    logic [1:0] rptr_next;
    logic [1:0] rptr_step;
    logic rd_slot;
    logic [1:0] wg_s1_reg, wg_s2_reg;
    // two-stage synchronisers for the sticky link-side flags
    logic pt_s1_reg, pt_s2_reg;
    logic ot_s1_reg, ot_s2_reg;
    logic [2:0] tm_s1_reg, tm_s2_reg;
    logic sel_s1_reg, sel_s2_reg;
    logic out_valid_reg, out_valid_next;
    dbr_pkg::dbr_word_type out_word_reg, out_word_next;
    dbr_pkg::dbr_timing_type timing_reg, timing_next;
    logic timing_en_reg, timing_en_next;
    logic perr_reg, perr_next;
    logic ovf_reg, ovf_next;
    logic buf_empty;

    assign buf_empty = (rptr_reg == wg_s2_reg);
    // read side uses the same gray step and entry select as the write side
    assign rptr_step = rptr_reg ^ (^rptr_reg ? `DBR_PTR_TWO : `DBR_PTR_ONE);
    assign rd_slot = rptr_reg[1] ^ rptr_reg[0];

    // output register stage of the buffer, timing relay and flags
    always_comb begin
        rptr_next = rptr_reg;
        out_valid_next = out_valid_reg;
        out_word_next = out_word_reg;
        if (out_valid_reg && i_out_ready) begin
            out_valid_next = 1'b0;
        end
        if (!buf_empty && (!out_valid_reg || i_out_ready)) begin
            out_word_next = mem_reg[rd_slot];
            out_valid_next = 1'b1;
            rptr_next = rptr_step;
        end
        timing_en_next = !sel_s2_reg;
        timing_next = sel_s2_reg ? '0 : tm_s2_reg;
        perr_next = perr_reg | pt_s2_reg;
        ovf_next = ovf_reg | ot_s2_reg;
    end

    // system-domain registers and synchronisers
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            rptr_reg <= `DBR_PTR_ZERO;
            wg_s1_reg <= `DBR_PTR_ZERO;
            wg_s2_reg <= `DBR_PTR_ZERO;
            pt_s1_reg <= 1'b0;
            pt_s2_reg <= 1'b0;
            ot_s1_reg <= 1'b0;
            ot_s2_reg <= 1'b0;
            tm_s1_reg <= 3'h0;
            tm_s2_reg <= 3'h0;
            sel_s1_reg <= 1'b1;
            sel_s2_reg <= 1'b1;
            out_valid_reg <= 1'b0;
            out_word_reg <= '0;
            timing_reg <= '0;
            timing_en_reg <= 1'b0;
            perr_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else begin
            rptr_reg <= rptr_next;
            wg_s1_reg <= wptr_reg;
            wg_s2_reg <= wg_s1_reg;
            pt_s1_reg <= perr_seen_reg; // sticky level, safe at any clock ratio
            pt_s2_reg <= pt_s1_reg;
            ot_s1_reg <= ovf_seen_reg;
            ot_s2_reg <= ot_s1_reg;
            tm_s1_reg <= {smp_win_reg, smp_mark_reg, smp_c1_reg};
            tm_s2_reg <= tm_s1_reg;
            sel_s1_reg <= i_add_timing_select;
            sel_s2_reg <= sel_s1_reg;
            out_valid_reg <= out_valid_next;
            out_word_reg <= out_word_next;
            timing_reg <= timing_next;
            timing_en_reg <= timing_en_next;
            perr_reg <= perr_next;
            ovf_reg <= ovf_next;
        end
    end

    assign o_out_valid = out_valid_reg;
    assign o_out_word = out_word_reg;
    assign o_add_timing = timing_reg;
    assign o_add_timing_en = timing_en_reg;
    assign o_parity_err = perr_reg;
    assign o_overflow = ovf_reg;
endmodule
`default_nettype wire

// ==== bench/dbr_receiver_properties.sv ====
// Purpose: port checks for the drop bus receiver
// Assumes: system clock domain only
// Notes: bound into dbr_receiver below
`timescale 1ns/1ps
`default_nettype none
module dbr_receiver_properties (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_add_timing_select,
    input wire logic i_out_ready,
    input wire logic o_out_valid,
    input wire dbr_pkg::dbr_word_type o_out_word,
    input wire dbr_pkg::dbr_timing_type o_add_timing,
    input wire logic o_add_timing_en,
    input wire logic o_parity_err
);
    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);
    // select held long enough to pass the synchroniser
    sequence sel_low_s;
        !i_add_timing_select [*5];
    endsequence
    sequence sel_high_s;
        i_add_timing_select [*5];
    endsequence
    timing_on_a: assert property (sel_low_s |=> o_add_timing_en)
        else $error("add timing not enabled");
    timing_off_a: assert property (sel_high_s |=> !o_add_timing_en && o_add_timing == 3'h0)
        else $error("add timing not off");
    word_hold_a: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_word))
        else $error("word changed while stalled");
    mark_or_a: assert property (o_out_valid && o_out_word.frame_mark |-> o_out_word.path_mark)
        else $error("frame pulse missing from composite");
    err_keep_a: assert property (o_parity_err |=> o_parity_err)
        else $error("parity flag dropped");
    err_flag_a: assert property (o_out_valid && o_out_word.parity_err |-> ##[0:6] o_parity_err)
        else $error("parity flag not raised");
endmodule
bind dbr_receiver dbr_receiver_properties u_props (.i_clk_sys, .i_reset, .i_add_timing_select,
    .i_out_ready, .o_out_valid, .o_out_word, .o_add_timing, .o_add_timing_en, .o_parity_err);
`default_nettype wire

// ==== bench/dbr_drop_source.sv ====
// Purpose: drop bus source model
// Assumes: receiver samples on the falling edge
// Notes: each byte is followed by overhead filler
`timescale 1ns/1ps
`default_nettype none
module dbr_drop_source (
    input wire logic i_clk,
    output logic [7:0] o_data,
    output logic o_par,
    output logic o_win,
    output logic o_mark,
    output logic o_pulse
);
    initial begin
        {o_data, o_win, o_mark, o_pulse} = 11'h000;
        o_par = 1'h1;
    end
    // one byte, then window-low filler whose data keeps changing
    task automatic send(input logic [7:0] d, input logic w, m, p, bad);
        @(posedge i_clk);
        {o_data, o_win, o_mark, o_pulse} <= {d, w, m, p};
        o_par <= ~^{d, w, m | p} ^ bad;
        for (int i = 0; i < 15; i++) begin
            @(posedge i_clk);
            {o_data, o_win, o_mark, o_pulse} <= {~d ^ 8'(i), 3'h0};
            o_par <= ~^{~d ^ 8'(i), 2'h0};
        end
    endtask
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: self-checking bench for the drop bus receiver
// Assumes: link clock 32 ns, system clock 100 ns
// Notes: words taken by the sink are queued for checking
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic i_clk_sys = 1'h0;
    logic i_drop_bus_clock = 1'h0;
    logic i_reset = 1'h1;
    logic i_add_timing_select = 1'h0;
    logic i_out_ready = 1'h1;
    logic [7:0] dd;
    logic drop_parity_bit, dwin, dmark, dpulse, o_out_valid, o_add_timing_en, o_parity_err, o_overflow;
    dbr_pkg::dbr_word_type o_out_word;
    dbr_pkg::dbr_timing_type o_add_timing;
    dbr_pkg::dbr_word_type got[$];
    int miscompares = 0;
    int check_count = 0;
    always #50 i_clk_sys = ~i_clk_sys;
    // link clock offset so its phase is unrelated
    initial begin
        #7;
        forever #16 i_drop_bus_clock = ~i_drop_bus_clock;
    end
    dbr_receiver dut (.i_clk_sys, .i_reset, .i_drop_bus_clock, .i_drop_data_byte(dd),
        .i_drop_parity_bit(drop_parity_bit), .i_drop_payload_window(dwin), .i_drop_frame_path_marker(dmark),
        .i_drop_frame_pulse(dpulse), .i_add_timing_select, .i_out_ready, .o_out_valid,
        .o_out_word, .o_add_timing, .o_add_timing_en, .o_parity_err, .o_overflow);
    dbr_drop_source src (.i_clk(i_drop_bus_clock), .o_data(dd), .o_par(drop_parity_bit), .o_win(dwin),
        .o_mark(dmark), .o_pulse(dpulse));
    // collect each word the sink takes
    always @(posedge i_clk_sys) begin
        if (o_out_valid === 1'h1 && i_out_ready === 1'h1) got.push_back(o_out_word);
    end
    task automatic results();
        $display("miscompares %0d check_count %0d", miscompares, check_count);
        if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [10:0] exp, input logic [10:0] act);
        check_count++;
        if (exp !== act) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, act);
        end
    endtask
    task automatic wait_words(input int n);
        for (int k = 0; k < 300 && got.size() < n; k++) @(negedge i_clk_sys);
        if (got.size() < n) begin
            miscompares++;
            results();
        end
    endtask
    task automatic t_timing();
        check("timing_en", 11'h001, 11'(o_add_timing_en));
        check("timing_idle", 11'h000, {8'h00, o_add_timing});
        i_add_timing_select = 1'h1;
        repeat (7) @(negedge i_clk_sys);
        check("timing_off", 11'h000, {o_add_timing_en, 7'h00, o_add_timing});
        i_add_timing_select = 1'h0;
        repeat (7) @(negedge i_clk_sys);
        check("timing_on", 11'h001, 11'(o_add_timing_en));
    endtask
    task automatic t_payload();
        got.delete();
        for (int i = 0; i < 4; i++) src.send(8'hA5 ^ 8'(i * 3), 1'h1, 1'h0, 1'h0, 1'h0);
        wait_words(4);
        for (int i = 0; i < 4; i++) check("payload", {8'hA5 ^ 8'(i * 3), 3'h0}, got[i]);
    endtask
    task automatic t_markers();
        got.delete();
        src.send(8'h3C, 1'h1, 1'h0, 1'h1, 1'h0);
        src.send(8'hC3, 1'h1, 1'h1, 1'h0, 1'h0);
        wait_words(2);
        check("pulse_word", {8'h3C, 3'h6}, got[0]);
        check("marker_word", {8'hC3, 3'h2}, got[1]);
    endtask
    task automatic t_stall();
        got.delete();
        check("overflow_idle", 11'h000, 11'(o_overflow));
        i_out_ready = 1'h0;
        for (int i = 0; i < 5; i++) src.send(8'h10 + 8'(i), 1'h1, 1'h0, 1'h0, 1'h0);
        @(negedge i_clk_sys);
        check("overflow", 11'h001, 11'(o_overflow));
        i_out_ready = 1'h1;
        wait_words(3);
        check("drain_first", {8'h10, 3'h0}, got[0]);
        check("drain_second", {8'h11, 3'h0}, got[1]);
        check("drain_third", {8'h12, 3'h0}, got[2]);
    endtask
    task automatic t_parity();
        repeat (10) @(negedge i_clk_sys);
        got.delete();
        check("err_idle", 11'h000, 11'(o_parity_err));
        src.send(8'h5A, 1'h1, 1'h0, 1'h0, 1'h1);
        wait_words(1);
        check("err_word", {8'h5A, 3'h1}, got[0]);
        check("err_flag", 11'h001, 11'(o_parity_err));
    endtask
    initial begin
        repeat (5) @(negedge i_clk_sys);
        i_reset = 1'h0;
        repeat (8) @(negedge i_clk_sys);
        t_timing();
        t_payload();
        t_markers();
        t_stall();
        t_parity();
        results();
    end
endmodule
`default_nettype wire
